// ---- rtl/dscr_receiver.v ----
// Two-wire receive-only command and data receiver for a 10-bit DAC
`timescale 1ns/1ps
`include "dscr_regs.vh"

// Function
// - Reference select output follows command bit 2: 0 supply, 1 bandgap.
// - First data byte holds code bits 7 down to 0.
// - Second data byte bits 1:0 hold code bits 9:8; rest ignored.
// - Address plus command byte only is accepted; only command is taken.
// - START/STOP between command ack and last data ack drops data bytes.
// - START/STOP before command ack drops the partial command byte.
// - Also answer shared sync address 1111110 as a quick command.
// - Sync with bit high and sync-update set copies inputs to outputs.
// - Sync with bit low clears all latches regardless of sync-update.
// - Sync with bit high and sync-update clear does nothing.
// - Full write acknowledged per byte; STOP copies inputs to outputs.
// - Slave address is 0100 plus three address strap inputs.
// - Sync-update set suppresses STOP update; defaults to zero.
// - Power-down bit takes effect at next STOP, data retained.
module dscr_receiver (
    // Clock, reset and enable
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_ce,
    // Bus pins
    input  wire       i_scl,
    input  wire       i_sda,
    output wire       o_sda,
    output wire       o_sda_oe_n,
    // Address straps
    input  wire       i_address_strap_2,
    input  wire       i_address_strap_1,
    input  wire       i_address_strap_0,
    // Converter controls
    output wire [9:0] o_code,
    output wire       o_reference_select,
    output wire       o_power_down,
    output wire       o_sync_update_enable
);

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    wire [4:0] pins_s;
    wire       scl_s;
    wire       sda_s;
    wire [2:0] strap_s;

    dscr_sync2 #(
        .W (5)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_async   ({i_scl, i_sda, i_address_strap_2,
                     i_address_strap_1, i_address_strap_0}),
        .o_sync    (pins_s)
    );

    assign scl_s   = pins_s[4];
    assign sda_s   = pins_s[3];
    assign strap_s = pins_s[2:0];

    // ==========================================================
    // Edge and condition detection
    // ==========================================================
    reg        scl_d_ff;
    reg        sda_d_ff;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_c;
    wire       stop_c;
    wire [6:0] own_addr;

    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign own_addr = {`DSCR_ADDR_HI, strap_s};

    // ==========================================================
    // Receive state
    // ==========================================================
    reg [2:0] phase_ff;
    reg [2:0] nxt_phase;
    reg [7:0] shift_ff;
    reg [3:0] bitcnt_ff;
    reg       in_ack_ff;
    reg       ack_drv_ff;
    reg       is_sync_ff;
    reg       ack_lock_ff;

    // Input registers and output latches
    reg [2:0] cmd_ff;
    reg [2:0] cmd_pend_ff;
    reg       cmd_new_ff;
    reg [7:0] low_in_ff;
    reg [1:0] high_in_ff;
    reg [7:0] low_pend_ff;
    reg [1:0] high_pend_ff;
    reg       low_pend_v_ff;
    reg [9:0] code_out_ff;
    reg       ref_ff;
    reg       pdn_ff;
    reg       sda_oe_n_ff;

    wire [7:0] rx_byte;
    wire       byte_done;
    wire       stop_update;
    wire       sync_hit;
    wire       own_hit;
    wire       ack_rise;
    wire       ack_fall;
    wire       ack_window;
    wire [9:0] code_in;

    // Byte completes on the eighth rising edge of the clock line
    assign rx_byte   = {shift_ff[6:0], sda_s};
    assign byte_done = scl_rise & (bitcnt_ff == 4'h7) & ~in_ack_ff;
    assign sync_hit  = rx_byte[7:1] == `DSCR_SYNC_ADDR;
    assign own_hit   = (rx_byte[7:1] == own_addr) & ~rx_byte[0];
    assign stop_update = ~cmd_ff[`DSCR_CMD_SYNC_BIT];

    // Acknowledge clock: first rise after a byte, then its fall
    assign ack_rise = in_ack_ff & scl_rise & ~ack_lock_ff;
    assign ack_fall = in_ack_ff & scl_fall & ack_lock_ff;

    // Input registers as one code word
    assign code_in = {high_in_ff, low_in_ff};

    // Next phase after a full byte
    always @* begin
        nxt_phase = phase_ff;
        case (phase_ff)
            `DSCR_PH_ADDR: begin
                if (sync_hit) begin
                    nxt_phase = `DSCR_PH_SKIP;
                end else if (own_hit) begin
                    nxt_phase = `DSCR_PH_CMD;
                end else begin
                    nxt_phase = `DSCR_PH_IDLE;
                end
            end
            `DSCR_PH_CMD:  nxt_phase = `DSCR_PH_LOW;
            `DSCR_PH_LOW:  nxt_phase = `DSCR_PH_HIGH;
            `DSCR_PH_HIGH: nxt_phase = `DSCR_PH_SKIP;
            default:       nxt_phase = phase_ff;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_d_ff      <= 1'b1;
            sda_d_ff      <= 1'b1;
            phase_ff      <= `DSCR_PH_IDLE;
            shift_ff      <= 8'h00;
            bitcnt_ff     <= 4'h0;
            in_ack_ff     <= 1'b0;
            ack_drv_ff    <= 1'b0;
            is_sync_ff    <= 1'b0;
            ack_lock_ff   <= 1'b0;
            cmd_ff        <= `DSCR_CMD_RST;
            cmd_pend_ff   <= `DSCR_CMD_RST;
            cmd_new_ff    <= 1'b0;
            low_in_ff     <= 8'h00;
            high_in_ff    <= 2'h0;
            low_pend_ff   <= 8'h00;
            low_pend_v_ff <= 1'b0;
            high_pend_ff  <= 2'h0;
            code_out_ff   <= `DSCR_CODE_RST;
            pdn_ff        <= 1'b0;
        end else if (i_ce) begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            if (start_c || stop_c) begin
                // Partial bytes and unfinished data are dropped
                phase_ff      <= start_c ? `DSCR_PH_ADDR
                                         : `DSCR_PH_IDLE;
                bitcnt_ff     <= 4'h0;
                in_ack_ff     <= 1'b0;
                ack_drv_ff    <= 1'b0;
                is_sync_ff    <= 1'b0;
                low_pend_v_ff <= 1'b0;
                if (cmd_new_ff) begin
                    cmd_ff <= cmd_pend_ff;
                end
                cmd_new_ff <= 1'b0;
                if (stop_c) begin
                    // A command still pending is taken by this STOP too
                    if (cmd_new_ff) begin
                        pdn_ff <= cmd_pend_ff[`DSCR_CMD_PDN_BIT];
                    end else begin
                        pdn_ff <= cmd_ff[`DSCR_CMD_PDN_BIT];
                    end
                    if (stop_update) begin
                        code_out_ff <= code_in;
                    end
                end
            end else if (phase_ff != `DSCR_PH_IDLE) begin
                if (byte_done) begin
                    shift_ff  <= rx_byte;
                    in_ack_ff <= 1'b1;
                    bitcnt_ff <= 4'h0;
                    phase_ff  <= nxt_phase;
                    ack_lock_ff <= 1'b0;
                    if (phase_ff == `DSCR_PH_ADDR) begin
                        is_sync_ff  <= sync_hit;
                        ack_drv_ff  <= sync_hit | own_hit;
                    end else begin
                        is_sync_ff <= 1'b0;
                        ack_drv_ff <= phase_ff != `DSCR_PH_SKIP;
                    end
                    case (phase_ff)
                        `DSCR_PH_CMD: begin
                            cmd_pend_ff <= rx_byte[2:0];
                            cmd_new_ff  <= 1'b1;
                        end
                        `DSCR_PH_LOW: begin
                            low_pend_ff   <= rx_byte;
                            low_pend_v_ff <= 1'b1;
                        end
                        `DSCR_PH_HIGH: begin
                            // Upper six bits are don't care
                            high_pend_ff <= rx_byte[1:0];
                        end
                        default: begin
                            low_pend_v_ff <= low_pend_v_ff;
                        end
                    endcase
                end else if (ack_rise) begin
                    ack_lock_ff <= 1'b1;
                    // Data pair is taken when the last data ack is clocked
                    if (phase_ff == `DSCR_PH_SKIP && low_pend_v_ff) begin
                        low_in_ff     <= low_pend_ff;
                        high_in_ff    <= high_pend_ff;
                        low_pend_v_ff <= 1'b0;
                    end
                    // Command is accepted once its acknowledge is clocked
                    if (cmd_new_ff && ack_drv_ff) begin
                        cmd_ff     <= cmd_pend_ff;
                        cmd_new_ff <= 1'b0;
                    end
                    if (is_sync_ff) begin
                        if (!shift_ff[0]) begin
                            // Clear every latch
                            cmd_ff      <= `DSCR_CMD_RST;
                            cmd_pend_ff <= `DSCR_CMD_RST;
                            low_in_ff   <= 8'h00;
                            high_in_ff  <= 2'h0;
                            code_out_ff <= `DSCR_CODE_RST;
                            pdn_ff      <= 1'b0;
                        end else if (cmd_ff[`DSCR_CMD_SYNC_BIT]) begin
                            code_out_ff <= code_in;
                        end
                    end
                end else if (ack_fall) begin
                    in_ack_ff  <= 1'b0;
                    ack_drv_ff <= 1'b0;
                    if (is_sync_ff) begin
                        phase_ff <= `DSCR_PH_IDLE;
                    end
                end else if (!in_ack_ff && scl_rise) begin
                    shift_ff  <= rx_byte;
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // Acknowledge drive
    // ==========================================================
    // Pull starts only once the clock is low behind the eighth bit, so a
    // one in that bit never turns into a false START
    assign ack_window = ack_lock_ff | ~scl_s | ~scl_d_ff;

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            sda_oe_n_ff <= 1'b1;
        end else if (i_ce) begin
            sda_oe_n_ff <= ~(ack_drv_ff & in_ack_ff & ack_window);
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Reference select follows the accepted command a cycle later
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ref_ff <= 1'b0;
        end else if (i_ce) begin
            ref_ff <= cmd_ff[`DSCR_CMD_REF_BIT];
        end
    end

    assign o_sda                = 1'b0;
    assign o_sda_oe_n           = sda_oe_n_ff;
    assign o_code               = code_out_ff;
    assign o_reference_select   = ref_ff;
    assign o_power_down         = pdn_ff;
    assign o_sync_update_enable = cmd_ff[`DSCR_CMD_SYNC_BIT];

endmodule // dscr_receiver

// ---- rtl/dscr_regs.vh ----
// Constants for the DAC serial command receiver
`ifndef DSCR_REGS_VH
`define DSCR_REGS_VH

// Slave address fields
`define DSCR_ADDR_HI        4'h4
`define DSCR_SYNC_ADDR      7'h7e

// Command byte field positions
`define DSCR_CMD_SYNC_BIT   0
`define DSCR_CMD_PDN_BIT    1
`define DSCR_CMD_REF_BIT    2

// Reset values
`define DSCR_CMD_RST        3'h0
`define DSCR_CODE_RST       10'h000

// Receive phases
`define DSCR_PH_IDLE        3'h0
`define DSCR_PH_ADDR        3'h1
`define DSCR_PH_CMD         3'h2
`define DSCR_PH_LOW         3'h3
`define DSCR_PH_HIGH        3'h4
`define DSCR_PH_SKIP        3'h5

`endif

// ---- rtl/dscr_sync2.v ----
// Two-flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps

module dscr_sync2 #(
    parameter W = 2
) (
    // Clock and control
    input  wire         i_clk,
    input  wire         i_sys_rst,
    input  wire         i_ce,
    // Data
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // Idle level of the bus lines is high
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_ff <= {W{1'b1}};
            sync_ff <= {W{1'b1}};
        end else if (i_ce) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule // dscr_sync2

// ---- verif/dscr_receiver_asserts.sv ----
// Concurrent checks on the receiver ports
`timescale 1ns/1ps
module dscr_receiver_chk (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    // Bus pins
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda,
    input wire logic       o_sda_oe_n,
    // Converter controls
    input wire logic [9:0] o_code,
    input wire logic       o_reference_select,
    input wire logic       o_power_down,
    input wire logic       o_sync_update_enable
);
    // ================================================
    // Port relations
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_reset_clears: assert property (disable iff (1'b0)
        i_sys_rst |=> !o_code && o_sda_oe_n && !o_power_down
        && !o_reference_select && !o_sync_update_enable)
        else $error("outputs not cleared by reset");
    a_ack_low_drive: assert property (
        $fell(o_sda_oe_n) |-> !i_scl && !o_sda)
        else $error("ack drive started with clock high");
    a_ack_holds: assert property (
        $rose(i_scl) && !o_sda_oe_n |=> !o_sda_oe_n [*4])
        else $error("ack released during ack clock");
    a_ref_on_ack: assert property (
        $changed(o_reference_select) |-> !o_sda_oe_n && i_scl)
        else $error("reference select moved outside an ack");
    a_sync_on_ack: assert property (
        $changed(o_sync_update_enable) |-> !o_sda_oe_n && i_scl)
        else $error("sync bit moved outside an ack");
    a_pdn_at_stop: assert property (
        $rose(o_power_down) |-> i_scl && i_sda)
        else $error("power down entered outside a stop");
    a_code_scl_high: assert property (
        $changed(o_code) |-> i_scl)
        else $error("code changed while clock low");
    a_code_sync_only: assert property (
        $changed(o_code) && $past(o_sync_update_enable) |-> !o_sda_oe_n)
        else $error("code updated by stop while sync set");
    a_code_stop_ack: assert property (
        $changed(o_code) |-> i_sda || !o_sda_oe_n)
        else $error("code changed with no stop or ack");
    c_code: cover property ($changed(o_code));
    c_pdn: cover property ($rose(o_power_down));
    c_sync_off: cover property ($fell(o_sync_update_enable));
endmodule // dscr_receiver_chk

bind dscr_receiver dscr_receiver_chk chk (.i_clk, .i_sys_rst, .i_scl,
    .i_sda, .o_sda, .o_sda_oe_n, .o_code, .o_reference_select,
    .o_power_down, .o_sync_update_enable);

// ---- verif/dscr_master.sv ----
// Two-wire bus master model driving clock and data
`timescale 1ns/1ps
module dscr_master (
    // Clock
    input  wire logic i_clk,
    // Bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // ================================================
    // Bus cycles, data bits changed only while the clock is low; edge3 moves data with the clock high
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Start is edge3(1,0), stop is edge3(0,1)
    task automatic edge3(input logic d1, input logic d2);
        o_scl <= 1'b0;
        wt(4);
        o_sda <= d1;
        wt(4);
        o_scl <= 1'b1;
        wt(8);
        o_sda <= d2;
        wt(8);
    endtask
    task automatic bit_io(input logic b, output logic s);
        o_scl <= 1'b0;
        wt(4);
        o_sda <= b;
        wt(4);
        o_scl <= 1'b1;
        wt(4);
        s = i_sda;
        wt(4);
    endtask
    // Most significant bit first, then a released ack bit when n is 8
    task automatic put(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 0; i < n; i++) bit_io(b[7-i], s);
        if (n == 8) begin
            bit_io(1'b1, s);
            ack = !s;
        end
    endtask
endmodule // dscr_master

// ---- verif/tb_dscr_receiver.sv ----
// Self-checking bench for the serial command receiver
`timescale 1ns/1ps
module tb_dscr_receiver;
    // ================================================
    // Clock, reset and bus
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] strap = 3'h5;
    logic       scl;
    logic       m_sda;
    wire        oe_n, drv, ref_sel, pdn, sync_en;
    wire  [9:0] code;
    wire        sda = m_sda & (oe_n | drv);
    int         n_errors = 0;
    int         checks = 0;
    always #5 clk = ~clk;
    dscr_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
    dscr_receiver uut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
        .i_scl(scl), .i_sda(sda), .o_sda(drv), .o_sda_oe_n(oe_n),
        .i_address_strap_2(strap[2]), .i_address_strap_1(strap[1]),
        .i_address_strap_0(strap[0]), .o_code(code),
        .o_reference_select(ref_sel), .o_power_down(pdn),
        .o_sync_update_enable(sync_en));
    // ================================================
    // Compares and transfers
    task automatic chk_code(input logic [9:0] exp);
        checks++;
        if (code !== exp) begin
            n_errors++;
            $display("unexpected at %0t: code %h not %h", $time, code, exp);
        end
    endtask
    task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: bits %b not %b", $time, got, exp);
        end
    endtask
    // n whole bytes, p bits of the next, then stop (st) or repeated start
    task automatic xfer(input logic [7:0] a, c, l, h, input int n, p,
                        input logic ea, st);
        logic       ack;
        logic [7:0] b [3];
        b = '{c, l, h};
        m.edge3(1'b1, 1'b0);
        m.put(a, 8, ack);
        chk_bits({2'h0, ack}, {2'h0, ea});
        for (int i = 0; i < n; i++) begin
            m.put(b[i], 8, ack);
            chk_bits({2'h0, ack}, 3'h1);
        end
        if (p > 0) m.put(b[n], p, ack);
        m.edge3(!st, st);
    endtask
    // ================================================
    // Scenarios
    task automatic t_reset();
        chk_code(10'h000);
        chk_bits({ref_sel, pdn, sync_en}, 3'h0);
        chk_bits({2'h0, oe_n}, 3'h1);
    endtask
    task automatic t_write();
        xfer(8'h4a, 8'h04, 8'ha5, 8'hfe, 3, 0, 1'b1, 1'b1);
        chk_code(10'h2a5);
        chk_bits({ref_sel, pdn, sync_en}, 3'h4);
    endtask
    task automatic t_addr();
        strap <= 3'h2;
        xfer(8'h4a, 8'h00, 8'h00, 8'h00, 0, 0, 1'b0, 1'b1);
        xfer(8'h45, 8'h00, 8'h00, 8'h00, 0, 0, 1'b0, 1'b1);
        xfer(8'h44, 8'h02, 8'h00, 8'h00, 1, 0, 1'b1, 1'b1);
        chk_bits({ref_sel, pdn, sync_en}, 3'h2);
        chk_code(10'h2a5);
        strap <= 3'h5;
    endtask
    task automatic t_abort();
        xfer(8'h4a, 8'h04, 8'h11, 8'h03, 2, 4, 1'b1, 1'b1);
        chk_code(10'h2a5);
        chk_bits({ref_sel, pdn, sync_en}, 3'h4);
        xfer(8'h4a, 8'hff, 8'h00, 8'h00, 0, 4, 1'b1, 1'b1);
        chk_bits({ref_sel, pdn, sync_en}, 3'h4);
    endtask
    task automatic t_sync();
        xfer(8'h4a, 8'h01, 8'hff, 8'h03, 3, 0, 1'b1, 1'b1);
        chk_code(10'h2a5);
        chk_bits({ref_sel, pdn, sync_en}, 3'h1);
        xfer(8'hfd, 8'h00, 8'h00, 8'h00, 0, 0, 1'b1, 1'b1);
        chk_code(10'h3ff);
        xfer(8'hfc, 8'h00, 8'h00, 8'h00, 0, 0, 1'b1, 1'b1);
        chk_code(10'h000);
        chk_bits({ref_sel, pdn, sync_en}, 3'h0);
        xfer(8'h4a, 8'h01, 8'hff, 8'h00, 3, 0, 1'b1, 1'b1);
        chk_code(10'h000);
        xfer(8'h4a, 8'h00, 8'h00, 8'h00, 1, 0, 1'b1, 1'b0);
        xfer(8'hfd, 8'h00, 8'h00, 8'h00, 0, 0, 1'b1, 1'b0);
        chk_code(10'h000);
        xfer(8'hfc, 8'h00, 8'h00, 8'h00, 0, 0, 1'b1, 1'b1);
        chk_code(10'h000);
    endtask
    // ================================================
    // Sequence, watchdog and verdict
    task automatic end_of_test();
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_write();
        t_addr();
        t_abort();
        t_sync();
        end_of_test();
    end
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule // tb_dscr_receiver
